// >>> core/slqc_pkg.sv
// Package for the serial link quick setup register bank.
// Assumes a single core clock and a parallel register access port from the
// serial control port, eight-bit data, one access per cycle.
package slqc_pkg;

  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_QUICK_SETUP = 13'h005E;
  localparam logic [ADDR_W-1:0] OFS_OUT_MODE = 13'h0063;
  localparam logic [ADDR_W-1:0] OFS_LANE_COUNT = 13'h006E;
  localparam logic [ADDR_W-1:0] OFS_FORMAT_A = 13'h0072;
  localparam logic [ADDR_W-1:0] OFS_FORMAT_B = 13'h0073;

  // Field widths and positions (all fields sit at bit 0)
  localparam int MODE_W = 4;
  localparam int FIELD_W = 5;
  localparam int FIELD_LSB = 0;

  // Values after reset
  localparam logic [DATA_W-1:0] RST_QUICK_SETUP = 8'h00;
  localparam logic [MODE_W-1:0] RST_OUT_MODE = 4'h0;
  localparam logic [FIELD_W-1:0] RST_LANE_COUNT = 5'h00;
  localparam logic [FIELD_W-1:0] RST_FORMAT_A = 5'h00;
  localparam logic [FIELD_W-1:0] RST_FORMAT_B = 5'h00;

  // Quick setup codes
  localparam logic [DATA_W-1:0] QS_NONE = 8'h00;
  localparam logic [DATA_W-1:0] QS_TWO_LANE = 8'h02;
  localparam logic [DATA_W-1:0] QS_FOUR_LANE = 8'h04;
  localparam logic [DATA_W-1:0] QS_SIX_LANE = 8'h06;
  localparam logic [DATA_W-1:0] QS_EIGHT_LANE = 8'h08;
  localparam logic [DATA_W-1:0] QS_DOUBLE_EIGHT = 8'h48;
  localparam logic [DATA_W-1:0] QS_SINGLE_HI_ONE = 8'h81;
  localparam logic [DATA_W-1:0] QS_SINGLE_HI_TWO = 8'h82;
  localparam logic [DATA_W-1:0] QS_SINGLE_LO_ONE = 8'h91;
  localparam logic [DATA_W-1:0] QS_DUAL_HI_ONE = 8'hC1;

  // Preset field values
  localparam logic [MODE_W-1:0] MODE_GENERIC = 4'h0;
  localparam logic [MODE_W-1:0] MODE_DOUBLE = 4'h4;
  localparam logic [MODE_W-1:0] MODE_SINGLE_HI = 4'h8;
  localparam logic [MODE_W-1:0] MODE_SINGLE_LO = 4'h9;
  localparam logic [MODE_W-1:0] MODE_DUAL_HI = 4'hC;
  localparam logic [FIELD_W-1:0] LANES_1 = 5'h00;
  localparam logic [FIELD_W-1:0] LANES_2 = 5'h01;
  localparam logic [FIELD_W-1:0] LANES_4 = 5'h03;
  localparam logic [FIELD_W-1:0] LANES_6 = 5'h05;
  localparam logic [FIELD_W-1:0] LANES_8 = 5'h07;
  localparam logic [FIELD_W-1:0] FMT_B = 5'h0B;
  localparam logic [FIELD_W-1:0] FMT_F = 5'h0F;

  // Register access request from the serial control port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } slqc_req_t;

  // Link configuration fields driven into the link logic
  typedef struct packed {
    logic [MODE_W-1:0] out_mode;
    logic [FIELD_W-1:0] lane_count;
    logic [FIELD_W-1:0] format_a;
    logic [FIELD_W-1:0] format_b;
  } slqc_cfg_t;

  // Decoded preset
  typedef struct packed {
    logic hit;
    slqc_cfg_t cfg;
  } slqc_preset_t;

endpackage : slqc_pkg

// >>> core/slqc_top.sv
// Serial link quick setup register and the link configuration fields it loads.
// Assumes register accesses arrive as single-cycle strobes on core_clk_i from
// the serial control port logic; write and read are not issued together.
// Notes on behaviour
// - Quick setup register clears itself after every write; reads return zero.
// - Writing quick setup only overwrites other link fields, nothing else.
// - Code zero loads nothing; link fields keep their values.
// - Code 0x02 loads mode 0x0, lanes 0x1, formats 0xB and 0xF.
// - Code 0x04 loads mode 0x0, lanes 0x3, formats 0xB and 0xF.
// - Code 0x06 loads mode 0x0, lanes 0x5, both formats 0xB.
// - Code 0x08 loads mode 0x0, lanes 0x7, formats 0xB and 0xF.
// - Code 0x48 loads mode 0x4, lanes 0x7, both formats 0xF.
// - Code 0x81 loads mode 0x8, lanes 0x0, both formats 0xF.
// - Code 0x82 loads mode 0x8, lanes 0x1, both formats 0xF.
// - Code 0x91 loads mode 0x9, lanes 0x0, both formats 0xF.
// - Code 0xC1 loads mode 0xC, lanes 0x0, both formats 0xF.
// - Unmapped or reserved codes change no field; register still clears.
`timescale 1ns/1ps
module slqc_top (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire slqc_pkg::slqc_req_t req_i,
  output logic [slqc_pkg::DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output slqc_pkg::slqc_cfg_t link_cfg_o
);
  import slqc_pkg::*;

  typedef struct packed {
    slqc_cfg_t cfg;
    logic [DATA_W-1:0] quick;
    logic [DATA_W-1:0] rd_data;
    logic rd_valid;
  } slqc_state_t;

  slqc_state_t state;
  slqc_state_t next_state;
  slqc_preset_t preset;

  function automatic slqc_preset_t decode_preset(input logic [DATA_W-1:0] code);
    slqc_preset_t p;
    p.hit = 1'b1;
    p.cfg = '0;
    unique case (code)
      QS_TWO_LANE: p.cfg = '{MODE_GENERIC, LANES_2, FMT_B, FMT_F};
      QS_FOUR_LANE: p.cfg = '{MODE_GENERIC, LANES_4, FMT_B, FMT_F};
      QS_SIX_LANE: p.cfg = '{MODE_GENERIC, LANES_6, FMT_B, FMT_B};
      QS_EIGHT_LANE: p.cfg = '{MODE_GENERIC, LANES_8, FMT_B, FMT_F};
      QS_DOUBLE_EIGHT: p.cfg = '{MODE_DOUBLE, LANES_8, FMT_F, FMT_F};
      QS_SINGLE_HI_ONE: p.cfg = '{MODE_SINGLE_HI, LANES_1, FMT_F, FMT_F};
      QS_SINGLE_HI_TWO: p.cfg = '{MODE_SINGLE_HI, LANES_2, FMT_F, FMT_F};
      QS_SINGLE_LO_ONE: p.cfg = '{MODE_SINGLE_LO, LANES_1, FMT_F, FMT_F};
      QS_DUAL_HI_ONE: p.cfg = '{MODE_DUAL_HI, LANES_1, FMT_F, FMT_F};
      default: p.hit = 1'b0;
    endcase
    return p;
  endfunction : decode_preset

  // Field readback; upper bits of each register read as zero
  function automatic logic [DATA_W-1:0] read_mux(input slqc_state_t s,
                                                 input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] d;
    d = '0;
    unique case (a)
      OFS_QUICK_SETUP: d = s.quick;
      OFS_OUT_MODE: d = {{(DATA_W-MODE_W){1'b0}}, s.cfg.out_mode};
      OFS_LANE_COUNT: d = {{(DATA_W-FIELD_W){1'b0}}, s.cfg.lane_count};
      OFS_FORMAT_A: d = {{(DATA_W-FIELD_W){1'b0}}, s.cfg.format_a};
      OFS_FORMAT_B: d = {{(DATA_W-FIELD_W){1'b0}}, s.cfg.format_b};
      default: d = '0;
    endcase
    return d;
  endfunction : read_mux

  assign preset = decode_preset(req_i.wdata);

  always_comb begin
    next_state = state;
    next_state.rd_valid = 1'b0;
    // Self clearing: the code is never held, so it cannot be read back
    next_state.quick = RST_QUICK_SETUP;
    if (req_i.wr) begin
      unique case (req_i.addr)
        OFS_QUICK_SETUP: begin
          // Preset is registered on the edge that samples the write; no link action beyond the load
          if (preset.hit) begin
            next_state.cfg = preset.cfg;
          end
        end
        OFS_OUT_MODE: next_state.cfg.out_mode = req_i.wdata[FIELD_LSB +: MODE_W];
        OFS_LANE_COUNT: next_state.cfg.lane_count = req_i.wdata[FIELD_LSB +: FIELD_W];
        OFS_FORMAT_A: next_state.cfg.format_a = req_i.wdata[FIELD_LSB +: FIELD_W];
        OFS_FORMAT_B: next_state.cfg.format_b = req_i.wdata[FIELD_LSB +: FIELD_W];
        default: next_state.cfg = state.cfg;
      endcase
    end else if (req_i.rd) begin
      next_state.rd_data = read_mux(state, req_i.addr);
      next_state.rd_valid = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state.cfg <= '{RST_OUT_MODE, RST_LANE_COUNT, RST_FORMAT_A, RST_FORMAT_B};
      state.quick <= RST_QUICK_SETUP;
      state.rd_data <= '0;
      state.rd_valid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign rd_data_o = state.rd_data;
  assign rd_valid_o = state.rd_valid;
  assign link_cfg_o = state.cfg;

endmodule : slqc_top

// >>> tb/slqc_checker.sv
// Checker for the quick setup register bank, bound to slqc_top.
// Sees only the top ports; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
module slqc_checker (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire slqc_pkg::slqc_req_t req_i,
  input wire logic [slqc_pkg::DATA_W-1:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire slqc_pkg::slqc_cfg_t link_cfg_o
);
  import slqc_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic qs_wr;
  // Write to the quick setup offset; presets land one edge later
  assign qs_wr = req_i.wr && req_i.addr == OFS_QUICK_SETUP;
  property p_qs_zero;
    req_i.rd && !req_i.wr && req_i.addr == OFS_QUICK_SETUP |=> rd_valid_o && rd_data_o == 8'h00;
  endproperty
  a_qs_zero: assert property (p_qs_zero) else $error("quick setup read not zero");
  property p_hold; !req_i.wr |=> $stable(link_cfg_o); endproperty
  a_hold: assert property (p_hold) else $error("link fields moved without a write");
  property p_zero; qs_wr && req_i.wdata == 8'h00 |=> $stable(link_cfg_o); endproperty
  a_zero: assert property (p_zero) else $error("code zero changed link fields");
  property p_two;
    qs_wr && req_i.wdata == 8'h02 |=> link_cfg_o == {4'h0, 5'h01, 5'h0B, 5'h0F};
  endproperty
  a_two: assert property (p_two) else $error("two lane preset wrong");
  property p_six;
    qs_wr && req_i.wdata == 8'h06 |=> link_cfg_o == {4'h0, 5'h05, 5'h0B, 5'h0B};
  endproperty
  a_six: assert property (p_six) else $error("six lane preset wrong");
  property p_dbl;
    qs_wr && req_i.wdata == 8'h48 |=> link_cfg_o == {4'h4, 5'h07, 5'h0F, 5'h0F};
  endproperty
  a_dbl: assert property (p_dbl) else $error("double rate preset wrong");
  property p_lo;
    qs_wr && req_i.wdata == 8'h91 |=> link_cfg_o == {4'h9, 5'h00, 5'h0F, 5'h0F};
  endproperty
  a_lo: assert property (p_lo) else $error("low band preset wrong");
  property p_rsv; qs_wr && req_i.wdata == 8'h42 |=> $stable(link_cfg_o); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code changed link fields");
  c_two: cover property (qs_wr && req_i.wdata == 8'h02);
  c_rsv: cover property (qs_wr && req_i.wdata == 8'h42);
  c_rd: cover property (rd_valid_o);
endmodule : slqc_checker
bind slqc_top slqc_checker u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .link_cfg_o(link_cfg_o));

// >>> tb/test_slqc_top.sv
// Self-checking bench for the quick setup register bank.
// Drives the parallel register port itself, 1 ns after each rising edge.
`timescale 1ns/1ps
module test_slqc_top;
  import slqc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  slqc_req_t req_i = '0;
  logic [DATA_W-1:0] rd_data_o;
  logic rd_valid_o;
  slqc_cfg_t link_cfg_o;
  int failures = 0;
  int check_count = 0;
  logic [7:0] codes [9] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h48, 8'h81, 8'h82, 8'h91, 8'hC1};
  logic [7:0] idle [4] = '{8'h00, 8'h01, 8'h42, 8'hC2};
  slqc_cfg_t presets [9] = '{{4'h0, 5'h01, 5'h0B, 5'h0F}, {4'h0, 5'h03, 5'h0B, 5'h0F},
    {4'h0, 5'h05, 5'h0B, 5'h0B}, {4'h0, 5'h07, 5'h0B, 5'h0F}, {4'h4, 5'h07, 5'h0F, 5'h0F},
    {4'h8, 5'h00, 5'h0F, 5'h0F}, {4'h8, 5'h01, 5'h0F, 5'h0F}, {4'h9, 5'h00, 5'h0F, 5'h0F},
    {4'hC, 5'h00, 5'h0F, 5'h0F}};
  slqc_top dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .link_cfg_o(link_cfg_o));
  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  task chk(input logic [18:0] seen, input logic [18:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One request per call with an idle cycle after, so no strobe is set twice in a step
  task acc(input logic w, input logic r, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    #1 req_i = '{w, r, a, d};
    @(posedge core_clk_i);
    #1 req_i = '0;
  endtask : acc
  task rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    acc(1'b0, 1'b1, a, 8'h00);
    chk({rd_valid_o, 10'h000, rd_data_o}, {1'b1, 10'h000, exp});
  endtask : rd
  task report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    chk(link_cfg_o, 19'h00000);
    for (int i = 0; i < 9; i++) begin
      acc(1'b1, 1'b0, OFS_QUICK_SETUP, codes[i]);
      chk(link_cfg_o, presets[i]);
      rd(OFS_QUICK_SETUP, 8'h00);
      rd(OFS_FORMAT_B, {3'h0, presets[i].format_b});
    end
    $display("test presets done");
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 1'b0, OFS_QUICK_SETUP, idle[i]);
      chk(link_cfg_o, presets[8]);
      rd(OFS_QUICK_SETUP, 8'h00);
    end
    $display("test idle codes done");
    acc(1'b1, 1'b0, OFS_QUICK_SETUP, 8'h08);
    acc(1'b1, 1'b0, OFS_LANE_COUNT, 8'h03);
    chk(link_cfg_o, {4'h0, 5'h03, 5'h0B, 5'h0F});
    rd(OFS_LANE_COUNT, 8'h03);
    rd(13'h0010, 8'h00);
    $display("test override done");
    @(posedge core_clk_i);
    #1 rst_n_i = 1'b0;
    @(posedge core_clk_i);
    #1 chk(link_cfg_o, 19'h00000);
    rst_n_i = 1'b1;
    rd(OFS_LANE_COUNT, 8'h00);
    acc(1'b1, 1'b0, OFS_QUICK_SETUP, 8'h04);
    chk(link_cfg_o, presets[1]);
    $display("test reset done");
    report_and_stop();
  end
endmodule : test_slqc_top
